// ===== irq_handler_pkg.sv
// Constants shared by the three-level interrupt handler and its testbench.
// Assumes an 8-bit register port with a 4-bit word address.
package irq_handler_pkg;

  localparam int unsigned NUM_GROUPS = 3;
  localparam int unsigned GROUP_W = 8;
  localparam int unsigned NUM_SRC = NUM_GROUPS * GROUP_W;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 8;

  // Group index inside the flag arrays; the number of a source is
  // group * GROUP_W + bit, so the high group holds sources 16 to 23
  localparam int unsigned GRP_LOW = 0;
  localparam int unsigned GRP_MID = 1;
  localparam int unsigned GRP_HIG = 2;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_HIGH_PENDING = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MID_PENDING = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_LOW_PENDING = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_ENABLES = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_MID_ENABLES = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LOW_ENABLES = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_TOP_PENDING_CODE = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE_LEVELS = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 4'h9;

  // Reset values
  localparam logic [GROUP_W-1:0] PENDING_RESET = 8'h00;
  localparam logic [GROUP_W-1:0] ENABLES_RESET = 8'h00;
  localparam logic [NUM_GROUPS-1:0] EVENT_RESET = 3'h0;
  localparam logic [CODE_W-1:0] NO_PENDING_CODE = 8'hFF;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

endpackage

// ===== irq_handler_sva.sv
// Port checker for the three-level interrupt handler.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module irq_handler_sva
  import irq_handler_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs
  input wire logic [NUM_SRC-1:0] srcRequest,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  // Outputs
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic coreIntLineFirst,
  input wire logic coreIntLineSecond,
  input wire logic coreIntLineThird
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  read_idle_a: assert property (!regRdStrobe |=> regRdData == READ_IDLE)
    else $error("read data not idle");
  first_rise_a: assert property ($rose(coreIntLineFirst) |-> $past(|srcRequest[23:16], 3))
    else $error("first line rose without a high source");
  second_rise_a: assert property ($rose(coreIntLineSecond) |-> $past(|srcRequest[15:8], 3))
    else $error("second line rose without a mid source");
  third_rise_a: assert property ($rose(coreIntLineThird) |-> $past(|srcRequest[7:0], 3))
    else $error("third line rose without a low source");
  first_fall_a: assert property ($fell(coreIntLineFirst)
    |-> $past(regWrStrobe && regAddr == ADDR_HIGH_PENDING))
    else $error("first line fell without a clear");
  level_read_a: assert property (regRdStrobe && regAddr == ADDR_ACTIVE_LEVELS |=> regRdData
    == {5'h00, $past(coreIntLineFirst), $past(coreIntLineSecond), $past(coreIntLineThird)})
    else $error("active levels differ from lines");
  code_none_a: assert property (regRdStrobe && regAddr == ADDR_TOP_PENDING_CODE
    && !(coreIntLineFirst | coreIntLineSecond | coreIntLineThird)
    |=> regRdData == NO_PENDING_CODE)
    else $error("code not all ones with nothing pending");
  code_high_a: assert property (regRdStrobe && regAddr == ADDR_TOP_PENDING_CODE
    && coreIntLineFirst |=> regRdData inside {[8'h10:8'h17]})
    else $error("code not in high group");
endmodule
`default_nettype wire

// ===== irq_source_model.sv
// Peripheral side: raises the requested source lines for two cycles.
// Assumes the bench gives a one-cycle mask of sources to fire.
`timescale 1ns/10ps
`default_nettype none
module irq_source_model
  import irq_handler_pkg::*;
(
  // Clock
  input wire logic clock,
  // Command from the bench
  input wire logic [NUM_SRC-1:0] fireMask,
  // Request lines
  output logic [NUM_SRC-1:0] srcRequest
);
  logic [NUM_SRC-1:0] holdReq = '0;
  initial srcRequest = '0;
  // Two cycles high so the synchroniser cannot miss a request
  always @(posedge clock) begin
    srcRequest <= fireMask | holdReq;
    holdReq <= fireMask;
  end
endmodule
`default_nettype wire

// ===== three_level_irq_handler.sv
// Three-level interrupt handler: 24 edge-triggered sources in three groups
// of eight, one core interrupt line per group, priority code and event IRQ.
// Assumes sources are asynchronous pins and the register master shares clock.
// Core lines and the event output are registered; read data lasts one cycle.
//
// Contract
// - Each of the 24 sources has its own flag, handled individually.
// - Sources 16-23 form the high group, 8-15 the mid group, 0-7 the low group.
// - High group drives the first core line, mid the second, low the third.
// - A readable code names the highest-priority pending source at once.
// - The high pending register holds source 16+n in bit n, all zero after reset.
// - Writing a one to a pending bit clears that flag.
// - A flag sets only on a rising source edge while its enable bit is one.
// - Writing a zero to a pending bit leaves that flag as it was.
// - The priority code reads the pending source number, or 0xFF with none set.
// - Sources are sampled on the system clock and raise the core line promptly.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module three_level_irq_handler
  import irq_handler_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Peripheral request lines, asynchronous
  input wire logic [NUM_SRC-1:0] srcRequest,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [DATA_W-1:0] regRdData,
  // Core interrupt lines
  output logic coreIntLineFirst,
  output logic coreIntLineSecond,
  output logic coreIntLineThird,
  // Event interrupt
  output logic eventIrq
);

  // Reset release synchroniser
  logic rstSync1_q;
  logic rstSync2_q;
  logic rstLocal_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  assign rstLocal_n = rstSync2_q;

  // Source synchroniser and edge detector state
  logic [NUM_SRC-1:0] srcSync1_q;
  logic [NUM_SRC-1:0] srcSync2_q;
  logic [NUM_SRC-1:0] srcPrev_q;
  logic [NUM_SRC-1:0] srcSync1_d;
  logic [NUM_SRC-1:0] srcSync2_d;
  logic [NUM_SRC-1:0] srcPrev_d;
  logic [NUM_SRC-1:0] srcRise;

  for (genvar s = 0; s < NUM_SRC; s++) begin : gSource
    always_comb begin
      srcSync1_d[s] = srcRequest[s];
      srcSync2_d[s] = srcSync1_q[s];
      srcPrev_d[s] = srcSync2_q[s];
      // Previous value resets low like an idle pin, so a pin low through reset gives no false edge; one held high shows an edge after release
      srcRise[s] = srcSync2_q[s] && !srcPrev_q[s];
    end
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      srcSync1_q <= '0;
      srcSync2_q <= '0;
      srcPrev_q <= '0;
    end else begin
      srcSync1_q <= srcSync1_d;
      srcSync2_q <= srcSync2_d;
      srcPrev_q <= srcPrev_d;
    end
  end

  // Pending flags and enables, one byte per group
  logic [NUM_GROUPS-1:0][GROUP_W-1:0] pending_q;
  logic [NUM_GROUPS-1:0][GROUP_W-1:0] pending_d;
  logic [NUM_GROUPS-1:0][GROUP_W-1:0] enables_q;
  logic [NUM_GROUPS-1:0][GROUP_W-1:0] enables_d;
  logic [NUM_GROUPS-1:0][GROUP_W-1:0] setVec;
  logic [NUM_GROUPS-1:0][GROUP_W-1:0] clrVec;
  logic [NUM_GROUPS-1:0] pendWrSel;
  logic [NUM_GROUPS-1:0] enWrSel;
  logic [NUM_GROUPS-1:0] groupEvent;
  logic [NUM_GROUPS-1:0] groupActive;

  always_comb begin
    pendWrSel = '0;
    enWrSel = '0;
    pendWrSel[GRP_HIG] = regWrStrobe && (regAddr == ADDR_HIGH_PENDING);
    pendWrSel[GRP_MID] = regWrStrobe && (regAddr == ADDR_MID_PENDING);
    pendWrSel[GRP_LOW] = regWrStrobe && (regAddr == ADDR_LOW_PENDING);
    enWrSel[GRP_HIG] = regWrStrobe && (regAddr == ADDR_HIGH_ENABLES);
    enWrSel[GRP_MID] = regWrStrobe && (regAddr == ADDR_MID_ENABLES);
    enWrSel[GRP_LOW] = regWrStrobe && (regAddr == ADDR_LOW_ENABLES);
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gGroup
      // Bit n of group g is source g*8+n
      always_comb begin
        setVec[g] = srcRise[g*GROUP_W +: GROUP_W] & enables_q[g];
        clrVec[g] = pendWrSel[g] ? regWrData : '0;
        // A new edge in the cycle of its clear keeps the flag set
        pending_d[g] = (pending_q[g] & ~clrVec[g]) | setVec[g];
        groupEvent[g] = |setVec[g];
        groupActive[g] = |pending_d[g];
      end

      // Enables only gate new edges; a flag already set stays set
      always_comb begin
        enables_d[g] = enWrSel[g] ? regWrData : enables_q[g];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pending_q <= {NUM_GROUPS{PENDING_RESET}};
    end else begin
      pending_q <= pending_d;
    end
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      enables_q <= {NUM_GROUPS{ENABLES_RESET}};
    end else begin
      enables_q <= enables_d;
    end
  end

  // Core lines follow the flags in the same cycle they set
  logic [NUM_GROUPS-1:0] coreLine_q;
  logic [NUM_GROUPS-1:0] coreLine_d;

  always_comb begin
    coreLine_d = groupActive;
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      coreLine_q <= '0;
    end else begin
      coreLine_q <= coreLine_d;
    end
  end

  assign coreIntLineFirst = coreLine_q[GRP_HIG];
  assign coreIntLineSecond = coreLine_q[GRP_MID];
  assign coreIntLineThird = coreLine_q[GRP_LOW];

  // Two-level priority encoder: each group finds its top flag, then the
  // highest busy group is taken; shallower than one 24-deep chain
  localparam int unsigned BIT_W = $clog2(GROUP_W);

  logic [NUM_GROUPS-1:0] groupBusy;
  logic [NUM_GROUPS-1:0][BIT_W-1:0] groupTop;
  logic [CODE_W-1:0] topCode;

  for (genvar e = 0; e < NUM_GROUPS; e++) begin : gEncode
    // Later iterations overwrite, so the largest bit wins
    always_comb begin
      groupBusy[e] = 1'b0;
      groupTop[e] = '0;
      for (int b = 0; b < GROUP_W; b++) begin
        if (pending_q[e][b]) begin
          groupBusy[e] = 1'b1;
          groupTop[e] = BIT_W'(b);
        end
      end
    end
  end

  always_comb begin
    topCode = NO_PENDING_CODE;
    for (int k = 0; k < NUM_GROUPS; k++) begin
      if (groupBusy[k]) begin
        topCode = CODE_W'(k * GROUP_W) | CODE_W'(groupTop[k]);
      end
    end
  end

  // Sticky event status, one bit per group, with mask
  logic [NUM_GROUPS-1:0] evtStatus_q;
  logic [NUM_GROUPS-1:0] evtStatus_d;
  logic [NUM_GROUPS-1:0] evtMask_q;
  logic [NUM_GROUPS-1:0] evtMask_d;
  logic evtStatusWr;
  logic evtMaskWr;
  logic eventIrq_q;
  logic eventIrq_d;

  assign evtStatusWr = regWrStrobe && (regAddr == ADDR_EVENT_STATUS);
  assign evtMaskWr = regWrStrobe && (regAddr == ADDR_EVENT_MASK);

  for (genvar v = 0; v < NUM_GROUPS; v++) begin : gEvent
    always_comb begin
      // Set wins over a simultaneous clear, so a fresh event is never lost
      evtStatus_d[v] = (evtStatus_q[v] && !(evtStatusWr && regWrData[v])) || groupEvent[v];
      evtMask_d[v] = evtMaskWr ? regWrData[v] : evtMask_q[v];
    end
  end

  // Built from the next values so the output rises with the status bit
  always_comb begin
    eventIrq_d = |(evtStatus_d & evtMask_d);
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      evtStatus_q <= EVENT_RESET;
      eventIrq_q <= 1'b0;
    end else begin
      evtStatus_q <= evtStatus_d;
      eventIrq_q <= eventIrq_d;
    end
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      evtMask_q <= EVENT_RESET;
    end else begin
      evtMask_q <= evtMask_d;
    end
  end

  assign eventIrq = eventIrq_q;

  // Read path: data valid only in the cycle after the read strobe
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdData_d;
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] activeWord;
  logic [DATA_W-1:0] evtStatusWord;
  logic [DATA_W-1:0] evtMaskWord;

  // Narrow registers read back with zeros above their bits
  assign activeWord = DATA_W'(coreLine_q);
  assign evtStatusWord = DATA_W'(evtStatus_q);
  assign evtMaskWord = DATA_W'(evtMask_q);

  always_comb begin
    unique case (regAddr)
      ADDR_HIGH_PENDING: rdMux = pending_q[GRP_HIG];
      ADDR_MID_PENDING: rdMux = pending_q[GRP_MID];
      ADDR_LOW_PENDING: rdMux = pending_q[GRP_LOW];
      ADDR_HIGH_ENABLES: rdMux = enables_q[GRP_HIG];
      ADDR_MID_ENABLES: rdMux = enables_q[GRP_MID];
      ADDR_LOW_ENABLES: rdMux = enables_q[GRP_LOW];
      ADDR_TOP_PENDING_CODE: rdMux = topCode;
      ADDR_ACTIVE_LEVELS: rdMux = activeWord;
      ADDR_EVENT_STATUS: rdMux = evtStatusWord;
      ADDR_EVENT_MASK: rdMux = evtMaskWord;
      default: rdMux = READ_IDLE;
    endcase
  end

  // Idle zero outside the answer cycle keeps the port quiet for the master
  always_comb begin
    rdData_d = regRdStrobe ? rdMux : READ_IDLE;
  end

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      rdData_q <= READ_IDLE;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

endmodule

`default_nettype wire

// ===== three_level_irq_handler_tb.sv
// Self-checking bench for the three-level interrupt handler.
// Assumes the source model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module three_level_irq_handler_tb import irq_handler_pkg::*;;
  logic clock = 0;
  logic rst_n = 0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrStrobe = 0;
  logic regRdStrobe = 0;
  logic rdLag = 0;
  logic [NUM_SRC-1:0] fireMask = '0;
  logic [NUM_SRC-1:0] srcRequest, m;
  logic [DATA_W-1:0] regRdData;
  logic coreIntLineFirst, coreIntLineSecond, coreIntLineThird, eventIrq;
  logic [DATA_W-1:0] expQ[$];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int top;
  always #20 clock = ~clock;
  irq_source_model i_irq_source_model (.clock, .fireMask, .srcRequest);
  three_level_irq_handler i_three_level_irq_handler (.clock, .rst_n, .srcRequest, .regAddr,
    .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .coreIntLineFirst,
    .coreIntLineSecond, .coreIntLineThird, .eventIrq);
  task automatic check(input logic [DATA_W-1:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input int a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    regAddr <= ADDR_W'(a);
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clock);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rd(input int a, input logic [DATA_W-1:0] e);
    expQ.push_back(e);
    @(posedge clock);
    regAddr <= ADDR_W'(a);
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
  endtask
  task automatic fire(input logic [NUM_SRC-1:0] s);
    @(posedge clock);
    fireMask <= s;
    @(posedge clock);
    fireMask <= '0;
    repeat (5) @(posedge clock);
  endtask
  task automatic irqIs(input logic v);
    @(negedge clock);
    check({7'h00, eventIrq}, {7'h00, v}, "event irq");
  endtask
  // Read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge clock) rdLag <= regRdStrobe;
  always @(negedge clock) if (rdLag) check(regRdData, expQ.pop_front(), "read data");
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(52));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int a = 0; a < 11; a++) rd(a, a == 6 ? NO_PENDING_CODE : READ_IDLE);
    fire('1);
    rd(7, 8'h00);
    $display("reset and disabled sources done");
    for (int g = 3; g < 6; g++) wr(g, 8'hFF);
    wr(9, 8'h07);
    for (int g = 3; g < 6; g++) rd(g, 8'hFF);
    rd(9, 8'h07);
    for (int i = 0; i < NUM_SRC; i++) begin
      fire(NUM_SRC'(1) << i);
      irqIs(1'b1);
      rd(7, 8'h01 << (i / 8));
      rd(2 - i / 8, 8'h01 << (i % 8));
      rd(6, DATA_W'(i));
      wr(2 - i / 8, 8'h00);
      rd(2 - i / 8, 8'h01 << (i % 8));
      wr(2 - i / 8, 8'h01 << (i % 8));
      rd(6, 8'hFF);
      wr(8, 8'h07);
    end
    $display("single sources done");
    for (int r = 0; r < 6; r++) begin
      m = NUM_SRC'($urandom);
      top = -1;
      for (int k = 0; k < NUM_SRC; k++) if (m[k]) top = k;
      fire(m);
      rd(7, {5'h00, |m[23:16], |m[15:8], |m[7:0]});
      rd(6, top < 0 ? 8'hFF : DATA_W'(top));
      for (int g = 0; g < 3; g++) wr(g, 8'hFF);
      wr(8, 8'h07);
    end
    $display("random groups done");
    wr(9, 8'h00);
    fire(24'h000008);
    irqIs(1'b0);
    rd(8, 8'h01);
    wr(9, 8'h01);
    irqIs(1'b1);
    wr(8, 8'h01);
    irqIs(1'b0);
    $display("event mask done");
    repeat (2) @(posedge clock);
    give_verdict();
  end
endmodule
bind three_level_irq_handler irq_handler_sva i_irq_handler_sva (.clock, .rst_n, .srcRequest,
  .regAddr, .regWrStrobe, .regRdStrobe, .regRdData, .coreIntLineFirst, .coreIntLineSecond,
  .coreIntLineThird);
`default_nettype wire
